// File: rtl/uhrx_ctrl.sv
// host receive endpoint control, status, irq and ep0 count
//
// Behaviour
// - dma enable drives receive dma request
// - no-nyet bit forces ack, never nyet
// - arm bit allows one toggle write
// - toggle readable; written only while armed
// - toggle-zero bit clears the data toggle
// - stall handshake sets flag and interrupt
// - request bit issues in; cleared on packet
// - flush drops packet only when ready
// - iso crc error flag follows packet ready
// - bulk nak timeout sets bit, halts
// - three empty attempts set error flag
// - error flag reads zero in iso
// - fifo full flag shows no room
// - packet ready sets flag and interrupt
// - ep0 byte count read only field
`timescale 1ns/1ps
`default_nettype none
`include "uhrx_map.svh"
module uhrx_ctrl
  import uhrx_pkg::*;
#(
  parameter int NAK_W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic high_speed,
  input wire logic rx_pkt_good,
  input wire logic rx_pkt_bad_crc,
  input wire logic rx_stall_hs,
  input wire logic rx_no_data,
  input wire logic rx_nak,
  input wire logic rx_toggle_adv,
  input wire logic rx_fifo_full,
  input wire logic [6:0] ep0_fifo_bytes,
  output logic in_token_go,
  output logic hs_ack,
  output logic hs_nyet,
  output logic fifo_flush,
  output logic rx_toggle,
  output logic dma_req,
  output logic irq
);
  uhrx_ph_e ph_r;
  logic dma_en_r;
  logic no_nyet_r;
  logic arm_r;
  logic tog_r;
  logic stall_r;
  logic req_r;
  logic crcnak_r;
  logic err_r;
  logic pkt_r;
  logic iso_r;
  logic [4:0] nak_m_r;
  logic [3:0] ist_r;
  logic [3:0] imsk_r;
  logic [15:0] bus_rdata_r;
  logic csr_wr;
  logic ist_wr;
  logic flush_go;
  logic pkt_set;
  logic pkt_clr;
  logic retry_hit;
  logic nak_hit;
  logic [NAK_W-1:0] nak_limit;
  logic [3:0] ev;
  uhrx_word_t csr_view;

  assign csr_wr = ce && bus_wr && (bus_addr == `UHRX_OFS_CSR);
  assign ist_wr = ce && bus_wr && (bus_addr == `UHRX_OFS_IST);
  assign pkt_set = rx_pkt_good;
  assign flush_go = csr_wr && bus_wdata[`UHRX_B_FLUSH] && pkt_r;
  assign pkt_clr = flush_go || (csr_wr && !bus_wdata[`UHRX_B_PKT]);

  // sequencing of in transactions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph_r <= PH_IDLE;
    end else if (ce) begin
      unique case (ph_r)
        PH_IDLE: begin
          if (in_token_go) begin
            ph_r <= PH_BUSY;
          end
        end
        PH_BUSY: begin
          if (nak_hit && !iso_r) begin
            ph_r <= PH_HALT;
          end else if (rx_pkt_good || rx_stall_hs || retry_hit) begin
            ph_r <= PH_IDLE;
          end
        end
        PH_HALT: begin
          if (!crcnak_r) begin
            ph_r <= PH_IDLE;
          end
        end
      endcase
    end
  end

  assign in_token_go = (ph_r == PH_IDLE) && req_r && !pkt_r && !stall_r && !err_r;

  // settings written by software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dma_en_r <= 1'b0;
      no_nyet_r <= 1'b0;
    end else if (csr_wr) begin
      dma_en_r <= bus_wdata[`UHRX_B_RX_DMA_REQUEST_ENABLE];
      no_nyet_r <= bus_wdata[`UHRX_B_NONYET];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      iso_r <= 1'b0;
      nak_m_r <= 5'h00;
    end else if (ce && bus_wr && (bus_addr == `UHRX_OFS_CFG)) begin
      iso_r <= bus_wdata[`UHRX_CFG_ISO];
      nak_m_r <= bus_wdata[4:0];
    end
  end

  // data toggle and its write arm
  always_ff @(posedge core_clk) begin
    if (rst) begin
      arm_r <= 1'b0;
    end else if (csr_wr) begin
      arm_r <= !arm_r && bus_wdata[`UHRX_B_ARM];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tog_r <= 1'b0;
    end else if (ce) begin
      if (csr_wr && bus_wdata[`UHRX_B_TOGZ]) begin
        tog_r <= 1'b0;
      end else if (csr_wr && arm_r) begin
        tog_r <= bus_wdata[`UHRX_B_TOG];
      end else if (rx_toggle_adv) begin
        tog_r <= !tog_r;
      end
    end
  end

  assign rx_toggle = tog_r;

  // stall, request and packet ready flags, set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stall_r <= 1'b0;
    end else if (ce) begin
      if (rx_stall_hs) begin
        stall_r <= 1'b1;
      end else if (csr_wr && !bus_wdata[`UHRX_B_STALL]) begin
        stall_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_r <= 1'b0;
    end else if (ce) begin
      if (csr_wr && bus_wdata[`UHRX_B_REQ]) begin
        req_r <= 1'b1;
      end else if (pkt_set || (csr_wr && !bus_wdata[`UHRX_B_REQ])) begin
        req_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pkt_r <= 1'b0;
    end else if (ce) begin
      if (pkt_set) begin
        pkt_r <= 1'b1;
      end else if (pkt_clr) begin
        pkt_r <= 1'b0;
      end
    end
  end

  // crc error in iso, nak halt in bulk
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crcnak_r <= 1'b0;
    end else if (ce) begin
      if (iso_r) begin
        if (pkt_set) begin
          crcnak_r <= rx_pkt_bad_crc;
        end else if (pkt_clr) begin
          crcnak_r <= 1'b0;
        end
      end else if (nak_hit) begin
        crcnak_r <= 1'b1;
      end else if (csr_wr && !bus_wdata[`UHRX_B_CRCNAK]) begin
        crcnak_r <= 1'b0;
      end
    end
  end

  // retry error after empty attempts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (ce) begin
      if (retry_hit && !iso_r) begin
        err_r <= 1'b1;
      end else if (csr_wr && !bus_wdata[`UHRX_B_ERR]) begin
        err_r <= 1'b0;
      end
    end
  end

  uhrx_evt_cnt #(.W(2)) u_retry (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .clear(rx_pkt_good || in_token_go),
    .step(rx_no_data),
    .limit(2'(`UHRX_RETRY_LIMIT)),
    .hit(retry_hit)
  );

  // halt on the nak beyond 2^(m-1) frames, 0 or 1 disables
  always_comb begin
    nak_limit = '0;
    if (nak_m_r >= 5'(`UHRX_NAK_M_MIN)) begin
      if (nak_m_r > 5'(`UHRX_NAK_M_MAX)) begin
        nak_limit = (NAK_W'(1) << (`UHRX_NAK_M_MAX - 1)) + NAK_W'(1);
      end else begin
        nak_limit = (NAK_W'(1) << (nak_m_r - 5'h01)) + NAK_W'(1);
      end
    end
  end

  uhrx_evt_cnt #(.W(NAK_W)) u_nak (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .clear(rx_pkt_good || rx_stall_hs || iso_r || (ph_r != PH_BUSY)),
    .step(rx_nak),
    .limit(nak_limit),
    .hit(nak_hit)
  );

  // handshake choice and dma request
  assign hs_ack = rx_pkt_good && !hs_nyet;
  assign hs_nyet = rx_pkt_good && high_speed && !no_nyet_r && rx_fifo_full;
  assign fifo_flush = flush_go;
  assign dma_req = dma_en_r && pkt_r;

  // interrupt status, write one to clear, set wins
  assign ev[`UHRX_I_PKT] = pkt_set;
  assign ev[`UHRX_I_STALL] = rx_stall_hs;
  assign ev[`UHRX_I_ERR] = retry_hit && !iso_r;
  assign ev[`UHRX_I_NAK] = nak_hit && !iso_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ist_r <= 4'h0;
    end else if (ce) begin
      ist_r <= ev | (ist_r & ~(ist_wr ? bus_wdata[3:0] : 4'h0));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      imsk_r <= 4'h0;
    end else if (ce && bus_wr && (bus_addr == `UHRX_OFS_IMSK)) begin
      imsk_r <= bus_wdata[3:0];
    end
  end

  assign irq = |(ist_r & imsk_r);

  // register read view
  always_comb begin
    csr_view = `UHRX_CSR_RST;
    csr_view[`UHRX_B_RX_DMA_REQUEST_ENABLE] = dma_en_r;
    csr_view[`UHRX_B_NONYET] = no_nyet_r;
    csr_view[`UHRX_B_ARM] = arm_r;
    csr_view[`UHRX_B_TOG] = tog_r;
    csr_view[`UHRX_B_STALL] = stall_r;
    csr_view[`UHRX_B_REQ] = req_r;
    csr_view[`UHRX_B_CRCNAK] = crcnak_r;
    csr_view[`UHRX_B_ERR] = err_r && !iso_r;
    csr_view[`UHRX_B_FULL] = rx_fifo_full;
    csr_view[`UHRX_B_PKT] = pkt_r;
    csr_view = csr_view & `UHRX_CSR_RW_MASK;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_rdata_r <= 16'h0000;
    end else if (ce) begin
      bus_rdata_r <= 16'h0000;
      if (bus_rd) begin
        unique case (bus_addr)
          `UHRX_OFS_CSR: bus_rdata_r <= csr_view;
          `UHRX_OFS_CNT0: bus_rdata_r <= {9'h000, ep0_fifo_bytes};
          `UHRX_OFS_IST: bus_rdata_r <= {12'h000, ist_r};
          `UHRX_OFS_IMSK: bus_rdata_r <= {12'h000, imsk_r};
          `UHRX_OFS_CFG: bus_rdata_r <= {7'h00, iso_r, 3'h0, nak_m_r};
          default: bus_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign bus_rdata = bus_rdata_r;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !ce);

  sequence s_flush_req;
    csr_wr && bus_wdata[`UHRX_B_FLUSH] && pkt_r && !rx_pkt_good;
  endsequence

  sequence s_csr_read;
    bus_rd && (bus_addr == `UHRX_OFS_CSR);
  endsequence

  AST_DMA_REQ: assert property (rx_pkt_good && dma_en_r && !csr_wr |=> dma_req)
    else $error("dma request missing with packet ready");
  AST_NO_NYET: assert property (no_nyet_r && rx_pkt_good |-> hs_ack && !hs_nyet)
    else $error("nyet sent while suppressed");
  AST_ARM_ONCE: assert property (csr_wr && arm_r |=> !arm_r)
    else $error("toggle arm not cleared after write");
  AST_TOG_WRITE: assert property (csr_wr && arm_r && !bus_wdata[`UHRX_B_TOGZ]
    |=> tog_r == $past(bus_wdata[`UHRX_B_TOG]))
    else $error("armed toggle write not stored");
  AST_TOG_IGNORE: assert property (csr_wr && !arm_r && !bus_wdata[`UHRX_B_TOGZ] && !rx_toggle_adv
    |=> $stable(tog_r))
    else $error("unarmed toggle write changed toggle");
  AST_TOG_ZERO: assert property (csr_wr && bus_wdata[`UHRX_B_TOGZ] |=> !rx_toggle)
    else $error("toggle not zeroed");
  AST_STALL: assert property (rx_stall_hs |=> stall_r && ist_r[`UHRX_I_STALL])
    else $error("stall flag or status not set");
  AST_REQ_CLR: assert property (rx_pkt_good && !(csr_wr && bus_wdata[`UHRX_B_REQ])
    |=> !req_r && pkt_r)
    else $error("request not cleared on packet ready");
  AST_FLUSH: assert property (s_flush_req |-> fifo_flush ##1 !pkt_r)
    else $error("flush did not clear packet ready");
  AST_FLUSH_IDLE: assert property (!pkt_r |-> !fifo_flush)
    else $error("flush acted without packet ready");
  AST_ISO_CRC: assert property (iso_r && rx_pkt_good && rx_pkt_bad_crc && !csr_wr
    |=> crcnak_r && pkt_r)
    else $error("iso crc error flag not set");
  AST_NAK_HALT: assert property (nak_hit && !iso_r |=> crcnak_r ##0 ph_r == PH_HALT)
    else $error("nak timeout did not halt");
  AST_RETRY: assert property (retry_hit && !iso_r |=> err_r ##0 ist_r[`UHRX_I_ERR])
    else $error("retry error not raised");
  AST_ISO_ERR: assert property ((s_csr_read and iso_r) |=> !bus_rdata[`UHRX_B_ERR])
    else $error("error flag visible in iso");
  AST_FULL: assert property (s_csr_read |=> bus_rdata[`UHRX_B_FULL] == $past(rx_fifo_full))
    else $error("fifo full flag wrong");
  AST_PKT_IRQ: assert property (rx_pkt_good && imsk_r[`UHRX_I_PKT] && !(ce && bus_wr)
    |=> irq && pkt_r)
    else $error("packet ready interrupt missing");
  AST_EP0: assert property (bus_rd && (bus_addr == `UHRX_OFS_CNT0)
    |=> bus_rdata == {9'h000, $past(ep0_fifo_bytes)})
    else $error("ep0 count read wrong");
  AST_RSVD: assert property (s_csr_read |=> (bus_rdata & ~`UHRX_CSR_RW_MASK) == 16'h0000)
    else $error("reserved bits not zero");
endmodule : uhrx_ctrl
`default_nettype wire

// File: rtl/uhrx_evt_cnt.sv
// event counter that pulses when a limit is reached
`timescale 1ns/1ps
`default_nettype none
module uhrx_evt_cnt #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic hit
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  assign count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
  assign hit = step && !clear && (limit != '0) && (count_nxt >= limit);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (ce) begin
      if (clear || hit) begin
        count_r <= '0;
      end else if (step) begin
        count_r <= count_nxt;
      end
    end
  end
endmodule : uhrx_evt_cnt
`default_nettype wire

// File: rtl/uhrx_map.svh
// register offsets, field positions, reset values and counts
`ifndef UHRX_MAP_SVH
`define UHRX_MAP_SVH
`define UHRX_OFS_CSR 8'h00
`define UHRX_OFS_CNT0 8'h04
`define UHRX_OFS_IST 8'h08
`define UHRX_OFS_IMSK 8'h0C
`define UHRX_OFS_CFG 8'h10
`define UHRX_CSR_RST 16'h0000
`define UHRX_B_RX_DMA_REQUEST_ENABLE 13
`define UHRX_B_NONYET 12
`define UHRX_B_ARM 10
`define UHRX_B_TOG 9
`define UHRX_B_TOGZ 7
`define UHRX_B_STALL 6
`define UHRX_B_REQ 5
`define UHRX_B_FLUSH 4
`define UHRX_B_CRCNAK 3
`define UHRX_B_ERR 2
`define UHRX_B_FULL 1
`define UHRX_B_PKT 0
`define UHRX_CSR_RW_MASK 16'h36FF
`define UHRX_I_PKT 0
`define UHRX_I_STALL 1
`define UHRX_I_ERR 2
`define UHRX_I_NAK 3
`define UHRX_CFG_ISO 8
`define UHRX_RETRY_LIMIT 3
`define UHRX_NAK_M_MIN 2
`define UHRX_NAK_M_MAX 16
`endif

// File: rtl/uhrx_pkg.sv
// types of the host receive endpoint control block
package uhrx_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_BUSY, PH_HALT} uhrx_ph_e;
  typedef logic [15:0] uhrx_word_t;
endpackage : uhrx_pkg

// File: testbench/uhrx_ctrl_tb.sv
// self-checking bench for the host receive endpoint control block
`timescale 1ns/1ps
`default_nettype none
module uhrx_ctrl_tb;
  logic core_clk, rst, ce, bus_wr, bus_rd, high_speed, rx_pkt_bad_crc, rx_fifo_full;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata, rd_v;
  logic [6:0] ep0_fifo_bytes;
  logic rx_pkt_good, rx_stall_hs, rx_no_data, rx_nak, rx_toggle_adv, tgt_busy;
  logic in_token_go, hs_ack, hs_nyet, fifo_flush, rx_toggle, dma_req, irq, fl_v;
  logic [2:0] mode;
  logic [3:0] naks;
  logic [1:0] last_hs;
  int err_count = 0;
  int total_checks = 0;

  uhrx_ctrl uhrx_ctrl_inst (.*);
  uhrx_usb_target uhrx_usb_target_inst (.*);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic results;
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(negedge core_clk);
    fl_v = fifo_flush;
    @(posedge core_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    rd_v = bus_rdata;
  endtask : rd

  // bounded watch of one status bit
  task automatic poll(input int b, input logic hit);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 30 && !got; i++) begin
      rd(8'h08);
      got = rd_v[b];
    end
    chk({15'h0000, got}, {15'h0000, hit});
    if (got !== hit) results();
  endtask : poll

  task automatic clr;
    wr(8'h08, 16'h000F);
    wr(8'h00, 16'h0000);
  endtask : clr

  // a write while the clock enable is low must leave no trace
  task automatic t_ce;
    ce <= 1'b0;
    wr(8'h00, 16'h2000);
    ce <= 1'b1;
    rd(8'h00);
    chk(rd_v, 16'h0000);
  endtask : t_ce

  task automatic t_resv;
    rd(8'h00);
    chk(rd_v, 16'h0000);
    wr(8'h00, 16'hC900);
    rd(8'h00);
    chk(rd_v, 16'h0000);
    rd(8'h20);
    chk(rd_v, 16'h0000);
  endtask : t_resv

  task automatic t_pkt;
    wr(8'h0C, 16'h000F);
    wr(8'h00, 16'h2020);
    poll(0, 1'b1);
    rd(8'h00);
    chk(rd_v & 16'hFDFF, 16'h2001);
    chk({14'h0000, dma_req, irq}, 16'h0003);
    rd(8'h04);
    chk(rd_v, 16'h003A);
    ep0_fifo_bytes <= 7'h05;
    rd(8'h04);
    chk(rd_v, 16'h0005);
    wr(8'h00, 16'h0011);
    chk({15'h0000, fl_v}, 16'h0001);
    rd(8'h00);
    chk(rd_v & 16'hFDFF, 16'h0000);
    wr(8'h00, 16'h0010);
    chk({15'h0000, fl_v}, 16'h0000);
    clr();
  endtask : t_pkt

  task automatic t_stall;
    wr(8'h0C, 16'h0000);
    mode <= 3'h1;
    wr(8'h00, 16'h0020);
    poll(1, 1'b1);
    rd(8'h00);
    chk(rd_v & 16'h0041, 16'h0040);
    chk({15'h0000, irq}, 16'h0000);
    wr(8'h0C, 16'h0002);
    @(negedge core_clk);
    chk({15'h0000, irq}, 16'h0001);
    clr();
    @(negedge core_clk);
    chk({15'h0000, irq}, 16'h0000);
  endtask : t_stall

  task automatic t_err;
    mode <= 3'h2;
    wr(8'h00, 16'h0020);
    poll(2, 1'b1);
    rd(8'h00);
    chk(rd_v & 16'h0005, 16'h0004);
    clr();
  endtask : t_err

  task automatic t_iso;
    wr(8'h10, 16'h0100);
    rx_pkt_bad_crc <= 1'b1;
    mode <= 3'h0;
    wr(8'h00, 16'h0020);
    poll(0, 1'b1);
    rd(8'h00);
    chk(rd_v & 16'h0009, 16'h0009);
    wr(8'h00, 16'h0000);
    rd(8'h00);
    chk(rd_v & 16'h0009, 16'h0000);
    rx_pkt_bad_crc <= 1'b0;
    mode <= 3'h2;
    wr(8'h00, 16'h0020);
    poll(2, 1'b0);
    rd(8'h00);
    chk(rd_v & 16'h0004, 16'h0000);
    wr(8'h00, 16'h0000);
    for (int i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (!tgt_busy) break;
    end
    chk({15'h0000, tgt_busy}, 16'h0000);
    if (tgt_busy) results();
    wr(8'h10, 16'h0000);
    clr();
  endtask : t_iso

  task automatic t_nak;
    wr(8'h10, 16'h0002);
    mode <= 3'h3;
    naks <= 4'h3;
    wr(8'h00, 16'h0020);
    poll(3, 1'b1);
    rd(8'h00);
    chk(rd_v & 16'h0009, 16'h0008);
    clr();
    rd(8'h00);
    chk(rd_v & 16'h0008, 16'h0000);
    wr(8'h10, 16'h0003);
    mode <= 3'h4;
    naks <= 4'h4;
    wr(8'h00, 16'h0020);
    poll(0, 1'b1);
    rd(8'h08);
    chk(rd_v & 16'h0008, 16'h0000);
    clr();
  endtask : t_nak

  task automatic t_tog;
    logic [15:0] tw [6] = '{16'h0080, 16'h0200, 16'h0400, 16'h0200, 16'h0000, 16'h0080};
    logic [15:0] te [6] = '{16'h0000, 16'h0000, 16'h0400, 16'h0200, 16'h0200, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, tw[i]);
      rd(8'h00);
      chk(rd_v & 16'h0600, te[i]);
      if (i == 4) chk({15'h0000, rx_toggle}, 16'h0001);
    end
  endtask : t_tog

  task automatic t_nyet;
    high_speed <= 1'b1;
    rx_fifo_full <= 1'b1;
    mode <= 3'h0;
    wr(8'h00, 16'h0020);
    poll(0, 1'b1);
    chk({14'h0000, last_hs}, 16'h0002);
    rd(8'h00);
    chk(rd_v & 16'h0003, 16'h0003);
    chk({15'h0000, dma_req}, 16'h0000);
    clr();
    wr(8'h00, 16'h1020);
    poll(0, 1'b1);
    chk({14'h0000, last_hs}, 16'h0001);
    clr();
    high_speed <= 1'b0;
    rx_fifo_full <= 1'b0;
  endtask : t_nyet

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 16'h0000;
    high_speed = 1'b0;
    rx_pkt_bad_crc = 1'b0;
    rx_fifo_full = 1'b0;
    ep0_fifo_bytes = 7'h3A;
    mode = 3'h0;
    naks = 4'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_ce();
    t_resv();
    t_pkt();
    t_stall();
    t_err();
    t_iso();
    t_nak();
    t_tog();
    t_nyet();
    results();
  end
endmodule : uhrx_ctrl_tb
`default_nettype wire

// File: testbench/uhrx_usb_target.sv
// behavioural usb target answering in transactions of the receive endpoint
`timescale 1ns/1ps
`default_nettype none
module uhrx_usb_target (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_token_go,
  input wire logic hs_ack,
  input wire logic hs_nyet,
  input wire logic [2:0] mode,
  input wire logic [3:0] naks,
  output logic rx_pkt_good,
  output logic rx_stall_hs,
  output logic rx_no_data,
  output logic rx_nak,
  output logic rx_toggle_adv,
  output logic tgt_busy,
  output logic [1:0] last_hs
);
  logic [5:0] step_r;
  logic [4:0] k;
  logic data_mode;
  assign k = step_r[5:1] - 5'h01;
  assign data_mode = (mode == 3'h0) || (mode == 3'h4);
  // slow answer: first reply five cycles after the token, then every other cycle
  always_ff @(posedge core_clk) begin
    rx_pkt_good <= 1'b0;
    rx_stall_hs <= 1'b0;
    rx_no_data <= 1'b0;
    rx_nak <= 1'b0;
    rx_toggle_adv <= 1'b0;
    if (rst) begin
      tgt_busy <= 1'b0;
      step_r <= 6'h00;
    end else if (!tgt_busy) begin
      tgt_busy <= in_token_go;
      step_r <= 6'h00;
    end else begin
      step_r <= step_r + 6'h01;
      if (step_r >= 6'h03 && step_r[0]) begin
        if (mode >= 3'h3 && k < {1'b0, naks}) begin
          rx_nak <= 1'b1;
        end else if (mode == 3'h2) begin
          rx_no_data <= 1'b1;
          tgt_busy <= (k < 5'h02);
        end else begin
          rx_pkt_good <= data_mode;
          rx_toggle_adv <= data_mode;
          rx_stall_hs <= (mode == 3'h1);
          tgt_busy <= 1'b0;
        end
      end
    end
  end
  // handshake returned for the last data packet
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_hs <= 2'h0;
    end else if (rx_pkt_good) begin
      last_hs <= {hs_nyet, hs_ack};
    end
  end
endmodule : uhrx_usb_target
`default_nettype wire
